// >>> include/ipt_consts.vh
`ifndef IPT_CONSTS_VH
`define IPT_CONSTS_VH

// clock period and times, in picoseconds unless noted
`define IPT_CLK_PS 100000
`define IPT_CYC_PER_MS (1000000000 / `IPT_CLK_PS)
`define IPT_T_IVAL_LT_MIN_PS 10000
`define IPT_T_IVAL_GT_MIN_PS 25000
`define IPT_T_WIDTH_MIN_PS 2500
`define IPT_T_HOLD_MIN_PS 25000
`define IPT_T_REARM_PS 12500
`define IPT_T_MAX_MS 20000
`define IPT_EVT_MAX 1000000000
`define IPT_EVT_MIN 1
// least times round up to whole cycles
`define IPT_CYC_UP(t) (((t) + `IPT_CLK_PS - 1) / `IPT_CLK_PS)

// register byte offsets
`define IPT_OFS_CTRL 8'h00
`define IPT_OFS_PATTERN 8'h04
`define IPT_OFS_LIMIT 8'h08
`define IPT_OFS_HOLDOFF 8'h0C
`define IPT_OFS_STATUS 8'h10
`define IPT_OFS_TRIGCNT 8'h14

// control fields
`define IPT_CTRL_EN 0
`define IPT_CTRL_PATTERN 1
`define IPT_CTRL_WT_LO 2
`define IPT_CTRL_WT_HI 3
`define IPT_CTRL_GREATER 4
`define IPT_CTRL_EXITED 5
`define IPT_CTRL_SRC_LO 6
`define IPT_CTRL_SRC_HI 7
`define IPT_CTRL_FALLING 8
`define IPT_CTRL_HO_LO 9
`define IPT_CTRL_HO_HI 10
`define IPT_CTRL_RESET 32'h0000_0000
`define IPT_CTRL_MASK 32'h0000_07FF

// width types
`define IPT_WT_NONE 2'h0
`define IPT_WT_PWIDTH 2'h1
`define IPT_WT_IWIDTH 2'h2

// hold-off modes
`define IPT_HO_ZERO 2'h0
`define IPT_HO_TIME 2'h1
`define IPT_HO_EVENTS 2'h2

// per-source pattern settings, two bits per source
`define IPT_PAT_X 2'h0
`define IPT_PAT_L 2'h1
`define IPT_PAT_H 2'h2
`define IPT_PAT_RESET 32'h0000_0000
`define IPT_PAT_MASK 32'h0000_003F

`define IPT_LIMIT_RESET 32'h0000_0001
`define IPT_HOLD_RESET 32'h0000_0001

`define IPT_RESP_OKAY 2'h0
`define IPT_RESP_SLVERR 2'h2

`endif

// >>> logic/ipt_span.v
`timescale 1ns/1ps
`default_nettype none

// measures cycles from start to stop and compares with a limit
module ipt_span (
  input wire clock, // sampling clock
  input wire reset, // synchronous, active high
  input wire start, // restart the measurement
  input wire stop, // evaluate the measurement
  input wire [31:0] limit, // limit in cycles
  input wire greater, // 1: pass when longer, 0: pass when shorter
  output wire hit // stop with a passing measurement
);

  reg [31:0] cnt_q;
  reg run_q;

  // a stop without a preceding start measures nothing
  assign hit = stop & run_q & (greater ? (cnt_q > limit) : (cnt_q < limit));

  always @(posedge clock) begin
    // RULE15 counter clears on reset
    if (reset) begin
      cnt_q <= 32'h0000_0000;
      run_q <= 1'b0;
    end else if (start) begin
      cnt_q <= 32'h0000_0001;
      run_q <= 1'b1;
    end else if (stop) begin
      run_q <= 1'b0;
    end else if (run_q && cnt_q != 32'hFFFF_FFFF) begin
      // saturate so a very long span still counts as long
      cnt_q <= cnt_q + 32'h0000_0001;
    end
  end

endmodule // ipt_span

`default_nettype wire

// >>> logic/ipt_trigger.v
`timescale 1ns/1ps
`default_nettype none
`include "ipt_consts.vh"

// Function
// RULE1: single-source interval shorter than limit fires; limit 10 ns to 20 s.
// RULE2: single-source interval longer than limit fires; limit 25 ns to 20 s.
// RULE3: interval mode is single-source with width type interval, then less/greater.
// RULE4: pattern uses channels one, two and four only; channel three ignored.
// RULE5: each pattern source is high, low or don't care.
// RULE6: pattern is AND of per-source matches; don't care always matches.
// RULE7: entered option fires when pattern goes false to true.
// RULE8: exited option fires when pattern goes true to false.
// RULE9: pattern event may be held off by time or by event count.
// RULE10: pattern event may be qualified by pattern duration less or greater.
// RULE11: pattern event may be qualified by interval between events less or greater.
// RULE12: hold-off time 25 ns to 20 s, event count 1 to 10^9.
// RULE13: zero hold-off still imposes 12.5 ns re-arm time.
// RULE14: width limits range 2.5 ns to 20 s.
// RULE15: trigger is a one-clock pulse; counters clear on synchronous reset.
module ipt_trigger #(
  parameter [31:0] MAX_CYC = `IPT_T_MAX_MS * `IPT_CYC_PER_MS, // 20 s in cycles
  parameter [31:0] MAX_EVT = `IPT_EVT_MAX // largest event hold-off
) (
  input wire clock, // 10 MHz sampling clock
  input wire reset, // synchronous, active high
  input wire [3:0] chan_in, // trigger comparator outputs, channels 1..4
  output reg trig_out, // one-cycle qualified trigger
  input wire [7:0] s_axi_awaddr, // write address
  input wire s_axi_awvalid, // write address valid
  output wire s_axi_awready, // write address ready
  input wire [31:0] s_axi_wdata, // write data
  input wire [3:0] s_axi_wstrb, // write byte strobes
  input wire s_axi_wvalid, // write data valid
  output wire s_axi_wready, // write data ready
  output reg [1:0] s_axi_bresp, // write response
  output reg s_axi_bvalid, // write response valid
  input wire s_axi_bready, // write response ready
  input wire [7:0] s_axi_araddr, // read address
  input wire s_axi_arvalid, // read address valid
  output wire s_axi_arready, // read address ready
  output reg [31:0] s_axi_rdata, // read data
  output reg [1:0] s_axi_rresp, // read response
  output reg s_axi_rvalid, // read data valid
  input wire s_axi_rready // read data ready
);

  function [31:0] clamp;
    input [31:0] v;
    input [31:0] lo;
    input [31:0] hi;
    begin
      clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    end
  endfunction

  function [31:0] merge;
    input [31:0] old;
    input [31:0] wd;
    input [3:0] strb;
    input [31:0] mask;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = wd[i*8 +: 8];
        end
      end
      merge = merge & mask;
    end
  endfunction

  function one_match;
    input [1:0] set;
    input lvl;
    begin
      one_match = (set == `IPT_PAT_H) ? lvl : ((set == `IPT_PAT_L) ? ~lvl : 1'b1);
    end
  endfunction

  localparam [31:0] IVAL_LT_MIN = `IPT_CYC_UP(`IPT_T_IVAL_LT_MIN_PS);
  localparam [31:0] IVAL_GT_MIN = `IPT_CYC_UP(`IPT_T_IVAL_GT_MIN_PS);
  localparam [31:0] WIDTH_MIN = `IPT_CYC_UP(`IPT_T_WIDTH_MIN_PS);
  localparam [31:0] HOLD_MIN = `IPT_CYC_UP(`IPT_T_HOLD_MIN_PS);
  localparam [31:0] REARM_CYC = `IPT_CYC_UP(`IPT_T_REARM_PS);
  localparam [31:0] EVT_MIN = `IPT_EVT_MIN;

  reg [31:0] ctrl_q;
  reg [31:0] pat_q;
  reg [31:0] limit_q;
  reg [31:0] hold_q;
  reg [31:0] trig_cnt_q;

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers

  reg [3:0] sync1_q;
  reg [3:0] sync2_q;
  reg [3:0] prev_q;

  always @(posedge clock) begin
    if (reset) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
      prev_q <= 4'h0;
    end else begin
      sync1_q <= chan_in;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  wire en = ctrl_q[`IPT_CTRL_EN];
  wire pat_mode = ctrl_q[`IPT_CTRL_PATTERN];
  wire [1:0] wtype = ctrl_q[`IPT_CTRL_WT_HI:`IPT_CTRL_WT_LO];
  wire greater = ctrl_q[`IPT_CTRL_GREATER];
  wire exited_opt = ctrl_q[`IPT_CTRL_EXITED];
  wire [1:0] src = ctrl_q[`IPT_CTRL_SRC_HI:`IPT_CTRL_SRC_LO];
  wire falling = ctrl_q[`IPT_CTRL_FALLING];
  wire [1:0] ho_mode = ctrl_q[`IPT_CTRL_HO_HI:`IPT_CTRL_HO_LO];

  ////////////////////////////////////////////////////////////////////////////
  // single-source edges and pattern events

  wire ss_cur = sync2_q[src];
  wire ss_old = prev_q[src];
  // same-polarity edges only, so the interval spans one full period
  wire ss_edge = en & ~pat_mode & (falling ? (ss_old & ~ss_cur) : (~ss_old & ss_cur));

  // RULE4 sources one, two, four
  // RULE5 per-source setting
  // RULE6 AND of matches
  wire match_now = one_match(pat_q[1:0], sync2_q[0]) & one_match(pat_q[3:2], sync2_q[1]) &
    one_match(pat_q[5:4], sync2_q[3]);
  wire match_old = one_match(pat_q[1:0], prev_q[0]) & one_match(pat_q[3:2], prev_q[1]) &
    one_match(pat_q[5:4], prev_q[3]);
  // RULE7 pattern entered
  wire pat_enter = en & pat_mode & match_now & ~match_old;
  // RULE8 pattern exited
  wire pat_exit = en & pat_mode & ~match_now & match_old;
  wire pat_ev = exited_opt ? pat_exit : pat_enter;

  ////////////////////////////////////////////////////////////////////////////
  // width and interval measurement

  wire [31:0] ival_lo = (pat_mode | ~greater) ? (pat_mode ? WIDTH_MIN : IVAL_LT_MIN) : IVAL_GT_MIN;
  // RULE1 less-than limit range
  // RULE2 greater-than limit range
  // RULE14 width limit range
  wire [31:0] ival_lim = clamp(limit_q, ival_lo, MAX_CYC);
  wire [31:0] pw_lim = clamp(limit_q, WIDTH_MIN, MAX_CYC);
  wire ival_ev = pat_mode ? pat_ev : ss_edge;
  wire ival_hit;
  wire pw_hit;
  reg last_pass_q;

  ipt_span u_ival (
    .clock(clock),
    .reset(reset | ~en), // disabling forgets the last edge, so no stale span
    .start(ival_ev),
    .stop(ival_ev),
    .limit(ival_lim),
    .greater(greater),
    .hit(ival_hit)
  );

  ipt_span u_pwid (
    .clock(clock),
    .reset(reset | ~en), // disabling forgets a half-measured pattern
    .start(pat_enter),
    .stop(pat_exit),
    .limit(pw_lim),
    .greater(greater),
    .hit(pw_hit)
  );

  // an entering pattern cannot know its own length yet, so it uses the last one
  always @(posedge clock) begin
    if (reset || !en) begin
      last_pass_q <= 1'b0;
    end else if (pat_exit) begin
      last_pass_q <= pw_hit;
    end
  end

  reg qual_ev;
  always @* begin
    qual_ev = 1'b0;
    if (!pat_mode) begin
      // RULE3 interval selection
      qual_ev = (wtype == `IPT_WT_IWIDTH) ? ival_hit : ss_edge;
    end else begin
      case (wtype)
        // RULE10 pattern duration
        `IPT_WT_PWIDTH: qual_ev = exited_opt ? pw_hit : (pat_enter & last_pass_q);
        // RULE11 pattern interval
        `IPT_WT_IWIDTH: qual_ev = ival_hit;
        default: qual_ev = pat_ev;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // hold-off and trigger output

  reg armed_q;
  reg [31:0] ho_cnt_q;
  reg [31:0] ho_target;
  wire fire = qual_ev & armed_q;
  wire [31:0] ho_next = ho_cnt_q + 32'h0000_0001;

  always @* begin
    case (ho_mode)
      // RULE12 time hold-off range
      `IPT_HO_TIME: ho_target = clamp(hold_q, HOLD_MIN, MAX_CYC);
      // RULE12 event hold-off range
      `IPT_HO_EVENTS: ho_target = clamp(hold_q, EVT_MIN, MAX_EVT);
      // RULE13 minimum re-arm
      default: ho_target = REARM_CYC;
    endcase
  end

  always @(posedge clock) begin
    // RULE15 clear hold-off counters
    if (reset || !en) begin
      armed_q <= 1'b1;
      ho_cnt_q <= 32'h0000_0000;
    end else if (fire) begin
      armed_q <= 1'b0;
      ho_cnt_q <= 32'h0000_0000;
    end else if (!armed_q) begin
      // RULE9 hold-off by time or events
      if (ho_mode != `IPT_HO_EVENTS || qual_ev) begin
        ho_cnt_q <= ho_next;
        if (ho_next >= ho_target) begin
          armed_q <= 1'b1;
        end
      end
    end
  end

  always @(posedge clock) begin
    // RULE15 single-clock trigger pulse
    if (reset) begin
      trig_out <= 1'b0;
      trig_cnt_q <= 32'h0000_0000;
    end else begin
      trig_out <= fire;
      if (fire) begin
        trig_cnt_q <= trig_cnt_q + 32'h0000_0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register bus slave

  reg aw_full_q;
  reg [7:0] aw_addr_q;
  reg w_full_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;

  assign s_axi_awready = ~aw_full_q & ~s_axi_bvalid;
  assign s_axi_wready = ~w_full_q & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  wire do_write = aw_full_q & w_full_q & ~s_axi_bvalid;
  wire wr_known = (aw_addr_q == `IPT_OFS_CTRL) || (aw_addr_q == `IPT_OFS_PATTERN) ||
    (aw_addr_q == `IPT_OFS_LIMIT) || (aw_addr_q == `IPT_OFS_HOLDOFF);

  always @(posedge clock) begin
    if (reset) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_full_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `IPT_RESP_OKAY;
      ctrl_q <= `IPT_CTRL_RESET;
      pat_q <= `IPT_PAT_RESET;
      limit_q <= `IPT_LIMIT_RESET;
      hold_q <= `IPT_HOLD_RESET;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? `IPT_RESP_OKAY : `IPT_RESP_SLVERR;
        case (aw_addr_q)
          `IPT_OFS_CTRL: ctrl_q <= merge(ctrl_q, w_data_q, w_strb_q, `IPT_CTRL_MASK);
          `IPT_OFS_PATTERN: pat_q <= merge(pat_q, w_data_q, w_strb_q, `IPT_PAT_MASK);
          `IPT_OFS_LIMIT: limit_q <= merge(limit_q, w_data_q, w_strb_q, 32'hFFFF_FFFF);
          `IPT_OFS_HOLDOFF: hold_q <= merge(hold_q, w_data_q, w_strb_q, 32'hFFFF_FFFF);
          default: ctrl_q <= ctrl_q;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always @(posedge clock) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `IPT_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `IPT_RESP_OKAY;
      case ({s_axi_araddr[7:2], 2'b00})
        `IPT_OFS_CTRL: s_axi_rdata <= ctrl_q;
        `IPT_OFS_PATTERN: s_axi_rdata <= pat_q;
        `IPT_OFS_LIMIT: s_axi_rdata <= limit_q;
        `IPT_OFS_HOLDOFF: s_axi_rdata <= hold_q;
        `IPT_OFS_STATUS: s_axi_rdata <= {26'h0, sync2_q, armed_q, match_now};
        `IPT_OFS_TRIGCNT: s_axi_rdata <= trig_cnt_q;
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `IPT_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // ipt_trigger

`default_nettype wire

// >>> verification/ipt_comp_model.sv
`timescale 1ns/1ps
`default_nettype none
// level comparators on the four inputs, already digitised
module ipt_comp_model (
  input wire logic clock, // sampling clock
  input wire logic [3:0] lvl, // requested input levels
  output logic [3:0] chan // comparator outputs
);
  // ideal comparator with no hysteresis; its output settles half a period away from the sampling edge
  always @(negedge clock) begin
    chan <= lvl;
  end
endmodule // ipt_comp_model
`default_nettype wire

// >>> verification/ipt_trigger_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module ipt_trigger_monitor (
  input wire logic clock, // sampling clock
  input wire logic reset, // sync reset
  input wire logic [3:0] chan_in, // comparator levels
  input wire logic trig_out, // trigger pulse
  input wire logic s_axi_awvalid, // aw valid
  input wire logic s_axi_awready, // aw ready
  input wire logic s_axi_wvalid, // w valid
  input wire logic s_axi_wready, // w ready
  input wire logic s_axi_bvalid, // b valid
  input wire logic s_axi_bready, // b ready
  input wire logic [1:0] s_axi_bresp, // b response
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic s_axi_rvalid, // r valid
  input wire logic s_axi_rready, // r ready
  input wire logic [31:0] s_axi_rdata // r data
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
////////////////////////////////////////
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
////////////////////////////////////////
  a_wr_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid) else $error("write not answered");
  a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid) else $error("read not answered");
  a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
  a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  a_trig_pulse: assert property (trig_out |=> !trig_out) else $error("trigger longer than one clock");
  a_reset_quiet: assert property ($past(reset) |-> !trig_out) else $error("trigger out of reset");
  // a trigger always follows a level change three clocks back, one clock of slack
  a_trig_cause: assert property (trig_out |-> ($past(chan_in, 3) != $past(chan_in, 4)) ||
    ($past(chan_in, 2) != $past(chan_in, 3))) else $error("trigger without input change");
endmodule // ipt_trigger_monitor
bind ipt_trigger ipt_trigger_monitor u_mon (.clock(clock), .reset(reset), .chan_in(chan_in),
  .trig_out(trig_out), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata));
`default_nettype wire

// >>> verification/ipt_trigger_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ipt_consts.vh"
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin fail_count++; $display("mismatch %s exp %0h got %0h", n, e, s); end end
module ipt_trigger_tb_top;
  typedef struct packed {logic [10:0] c; logic [5:0] p; logic [7:0] h; logic [3:0] f; logic [3:0] t; logic [3:0] e;} ipt_row_t;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [3:0] lvl = 4'h0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  wire logic [3:0] chan;
  wire logic trig, awready, wready, bvalid, arready, rvalid;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  int fail_count = 0, n_checks = 0, cyc = 0, tcnt = 0, base = 0;
  int gaps [7] = '{8, 8, 3, 8, 8, 2, 8};
  logic [31:0] rv [4] = '{`IPT_CTRL_RESET, `IPT_PAT_RESET, `IPT_LIMIT_RESET, `IPT_HOLD_RESET};
  // control, pattern, hold-off, levels before/after (equal: pulse train on ch1), trigger count
  ipt_row_t rows [18] = '{
    '{11'h009, 6'h00, 8'h01, 4'h0, 4'h0, 4'h2},
    '{11'h019, 6'h00, 8'h01, 4'h0, 4'h0, 4'h5},
    '{11'h001, 6'h00, 8'h01, 4'h0, 4'h0, 4'h8},
    '{11'h401, 6'h00, 8'h02, 4'h0, 4'h0, 4'h3},
    '{11'h201, 6'h00, 8'h14, 4'h0, 4'h0, 4'h2},
    '{11'h003, 6'h26, 8'h01, 4'h0, 4'h9, 4'h1},
    '{11'h003, 6'h26, 8'h01, 4'h0, 4'hD, 4'h1},
    '{11'h003, 6'h26, 8'h01, 4'h9, 4'hD, 4'h0},
    '{11'h003, 6'h26, 8'h01, 4'h0, 4'hB, 4'h0},
    '{11'h023, 6'h26, 8'h01, 4'h9, 4'h1, 4'h1},
    '{11'h003, 6'h00, 8'h01, 4'h0, 4'hF, 4'h0},
    '{11'h003, 6'h04, 8'h01, 4'h2, 4'h0, 4'h1},
    '{11'h00B, 6'h02, 8'h01, 4'h0, 4'h0, 4'h2},
    '{11'h01B, 6'h02, 8'h01, 4'h0, 4'h0, 4'h5},
    '{11'h027, 6'h02, 8'h01, 4'h0, 4'h0, 4'h8},
    '{11'h037, 6'h02, 8'h01, 4'h0, 4'h0, 4'h0},
    '{11'h007, 6'h02, 8'h01, 4'h0, 4'h0, 4'h7},
    '{11'h109, 6'h00, 8'h01, 4'h0, 4'h0, 4'h2}
  };
  always #50 clock = ~clock;
  ipt_comp_model comp (.clock(clock), .lvl(lvl), .chan(chan));
  ipt_trigger #(.MAX_CYC(32'h0000_03E8), .MAX_EVT(32'h0000_0064)) dut (
    .clock(clock), .reset(reset), .chan_in(chan), .trig_out(trig),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
////////////////////////////////////////
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // each bus task opens on a fresh edge so no signal is assigned twice in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    `CHK("bresp", r, bresp)
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    `CHK("rdata", d, rdata)
    `CHK("rresp", r, rresp)
  endtask
  task automatic go(input logic [3:0] v, input int n);
    @(posedge clock);
    lvl <= v;
    repeat (n - 1) @(posedge clock);
  endtask
  task automatic cfg(input ipt_row_t r);
    wr(8'h00, 32'h0000_0000, 2'h0);
    wr(8'h04, 32'(r.p), 2'h0);
    wr(8'h08, 32'h0000_0005, 2'h0);
    wr(8'h0C, 32'(r.h), 2'h0);
    wr(8'h00, 32'(r.c), 2'h0);
  endtask
////////////////////////////////////////
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (trig === 1'b1) tcnt <= tcnt + 1;
    if (cyc == 6000) begin
      fail_count++;
      end_of_test;
    end
  end
  initial begin
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    for (int i = 0; i < 4; i++) rd(8'(i * 4), rv[i], 2'h0);
    rd(8'h14, 32'h0000_0000, 2'h0); // trigger count cleared
    rd(8'h18, 32'h0000_0000, 2'h2);
    wr(8'h10, 32'h0000_0001, 2'h2);
    wr(8'h20, 32'h0000_0001, 2'h2);
    wr(8'h00, 32'hFFFF_F800, 2'h0);
    rd(8'h00, 32'h0000_0000, 2'h0);
    foreach (rows[i]) begin
      go(rows[i].f, 4);
      cfg(rows[i]);
      go(rows[i].f, 6);
      base = tcnt;
      if (rows[i].f == rows[i].t) begin
        for (int k = 0; k < 8; k++) begin
          go(4'h1, 1);
          go(4'h0, (k < 7) ? gaps[k] - 1 : 8);
        end
      end else begin
        go(rows[i].t, 10);
      end
      `CHK("trigs", rows[i].e, 4'(tcnt - base)) // per-row count
    end
    // an edge already in the synchroniser must not survive a reset
    cfg(rows[2]);
    go(4'h0, 4);
    base = tcnt;
    go(4'h1, 1);
    @(posedge clock);
    reset <= 1'b1;
    lvl <= 4'h0;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    repeat (6) @(posedge clock);
    `CHK("reset trigs", 4'h0, 4'(tcnt - base))
    rd(8'h00, `IPT_CTRL_RESET, 2'h0);
    rd(8'h10, 32'h0000_0003, 2'h0);
    rd(8'h14, 32'h0000_0000, 2'h0);
    end_of_test;
  end
endmodule // ipt_trigger_tb_top
`default_nettype wire
